// *** rtl/pcu_defines.svh ***
`ifndef PCU_DEFINES_SVH
`define PCU_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define PCU_ADDR_CONFIG 16'h2400
`define PCU_ADDR_FLAGS 16'h2401
`define PCU_ADDR_INDEX_POS 16'h2402
`define PCU_ADDR_HOME_POS 16'h2403
`define PCU_ADDR_FAST_TS 16'h2404
`define PCU_ADDR_FAST_MOTOR 16'h2405
`define PCU_ADDR_FAST_LOAD 16'h2406

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define PCU_CFG_IDX_RISE 0
`define PCU_CFG_IDX_FALL 1
`define PCU_CFG_IDX_HOLD 2
`define PCU_CFG_HOME_FALL 5
`define PCU_CFG_HOME_HOLD 6
`define PCU_CFG_FAST_EN 8
`define PCU_CFG_FAST_HOLD 10
`define PCU_CFG_IDX_ZERO 12

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define PCU_ST_IDX_NEW 0
`define PCU_ST_IDX_OVR 3
`define PCU_ST_HOME_NEW 4
`define PCU_ST_HOME_OVR 7
`define PCU_ST_FAST_NEW 8
`define PCU_ST_FAST_OVR 11

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PCU_CONFIG_RESET 16'h0000
`define PCU_CLK_PERIOD_NS 10
`define PCU_US_NS 1000
`define PCU_CYC_PER_US (`PCU_US_NS / `PCU_CLK_PERIOD_NS)

`endif

// *** rtl/pcu_pkg.sv ***
package pcu_pkg;

    typedef logic [15:0] pcu_index_t;
    typedef logic [15:0] pcu_word16_t;
    typedef logic signed [31:0] pcu_word32_t;

    // Input channel numbering for the edge detector
    typedef enum logic [1:0] {
        PCU_CH_INDEX = 2'b00,
        PCU_CH_HOME = 2'b01,
        PCU_CH_FAST = 2'b10
    } pcu_chan_t;

endpackage : pcu_pkg

// *** rtl/pcu_top.sv ***
`timescale 1ns/100ps
`include "pcu_defines.svh"
// How it works
// - Config bit 0 set: index rising edge stores axis position in index capture.
// - Config bit 1 set: index falling edge stores axis position in index capture.
// - Config bit 2 set: unread index capture is kept; else new capture replaces it.
// - Config bit 5 picks home edge: set active-to-inactive, clear inactive-to-active.
// - Config bit 6 set: unread home capture is kept; else replaced.
// - Config bit 8 enables high-speed capture into the fast motor position register.
// - Config bit 10 set: unread fast capture is kept, later events dropped.
// - Config bit 12 set: actual position cleared on every index pulse.
// - Status bit 0 flags a new index capture, cleared by reading it.
// - Status bit 3 flags an index event while an unread capture is held.
// - Status bit 4 flags a new home capture, cleared by reading it.
// - Status bit 7 flags a home event while an unread capture is held.
// - Status bit 8 flags a new fast capture, cleared by reading the fast motor capture.
// - Status bit 11 flags a fast event while an unread capture is held.
// - Reading the index capture clears status bits 0 and 3 together.
// - Index capture is a read-only signed 32-bit position in counts.
// - Home capture is a read-only signed 32-bit position taken on selected edge.
// - Each fast capture records a microsecond time stamp, also software-writable.
// - Fast motor capture is a read-only signed 32-bit motor position.
// - Separate read-only load position register taken at each fast capture.
module pcu_top
    import pcu_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    input wire logic index_i,
    input wire logic home_i,
    input wire logic fast_i,
    input wire logic signed [POS_W-1:0] motor_pos_i,
    input wire logic signed [POS_W-1:0] load_pos_i,
    output logic pos_clear_o
);

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (POS_W < 2 || POS_W > 32) begin : g_bad_pos_w
        $error("POS_W must lie in 2..32");
    end
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end
    // Microsecond divider needs at least two clocks per microsecond
    if (`PCU_CYC_PER_US < 2) begin : g_bad_us
        $error("clock too slow for the microsecond time base");
    end

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;

    // Assert at once, release two edges after the pin rises
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------
    // Input synchronisers and edge detect
    // ----------------------------------------
    logic [2:0] pin_in;
    logic [2:0] rise;
    logic [2:0] fall;

    assign pin_in[PCU_CH_INDEX] = index_i;
    assign pin_in[PCU_CH_HOME] = home_i;
    assign pin_in[PCU_CH_FAST] = fast_i;

    // Detectors start low: a pin held high through reset gives one rise
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            logic [SYNC_STAGES-1:0] sync_reg;
            logic last_reg;
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    sync_reg <= '0;
                    last_reg <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_in[g]};
                    last_reg <= sync_reg[SYNC_STAGES-1];
                end
            end
            assign rise[g] = sync_reg[SYNC_STAGES-1] & ~last_reg;
            assign fall[g] = ~sync_reg[SYNC_STAGES-1] & last_reg;
        end
    endgenerate

    // ----------------------------------------
    // Control register and register access
    // ----------------------------------------
    pcu_word16_t config_reg;
    logic rd_index;
    logic rd_home;
    logic rd_fast;
    logic wr_config;
    logic wr_stamp;

    // Writes to read-only indices fall through unused
    assign wr_config = wr_i && addr_i == `PCU_ADDR_CONFIG;
    assign wr_stamp = wr_i && addr_i == `PCU_ADDR_FAST_TS;

    // All 16 bits are kept, reserved ones included
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= `PCU_CONFIG_RESET;
        end else if (wr_config) begin
            config_reg <= wdata_i[15:0];
        end
    end

    // Only reads of a capture register clear its flags
    assign rd_index = rd_i && addr_i == `PCU_ADDR_INDEX_POS;
    assign rd_home = rd_i && addr_i == `PCU_ADDR_HOME_POS;
    assign rd_fast = rd_i && addr_i == `PCU_ADDR_FAST_MOTOR;

    // ----------------------------------------
    // Capture events
    // ----------------------------------------
    logic idx_ev;
    logic home_ev;
    logic fast_ev;

    // Either index edge may be enabled, or both
    assign idx_ev = (rise[PCU_CH_INDEX] & config_reg[`PCU_CFG_IDX_RISE])
        | (fall[PCU_CH_INDEX] & config_reg[`PCU_CFG_IDX_FALL]);
    assign home_ev = config_reg[`PCU_CFG_HOME_FALL] ? fall[PCU_CH_HOME] : rise[PCU_CH_HOME];
    // Fast input counts only while enabled, on becoming active
    assign fast_ev = rise[PCU_CH_FAST] & config_reg[`PCU_CFG_FAST_EN];

    // ----------------------------------------
    // Index capture and flags
    // ----------------------------------------
    logic signed [POS_W-1:0] index_pos_reg;
    logic idx_new_reg;
    logic idx_ovr_reg;
    logic idx_held;
    logic idx_take;

    // A read in the same cycle frees the slot for the new event
    assign idx_held = idx_new_reg & ~rd_index;
    assign idx_take = idx_ev & ~(idx_held & config_reg[`PCU_CFG_IDX_HOLD]);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            index_pos_reg <= '0;
        end else if (idx_take) begin
            index_pos_reg <= motor_pos_i;
        end
    end

    // Hold mode drops the value but still flags the overrun
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            idx_new_reg <= 1'b0;
            idx_ovr_reg <= 1'b0;
        end else begin
            idx_new_reg <= idx_ev | idx_held;
            idx_ovr_reg <= (idx_ev & idx_held) | (idx_ovr_reg & ~rd_index);
        end
    end

    // ----------------------------------------
    // Home capture and flags
    // ----------------------------------------
    logic signed [POS_W-1:0] home_pos_reg;
    logic home_new_reg;
    logic home_ovr_reg;
    logic home_held;
    logic home_take;

    // Same-cycle read frees the slot, as for the index
    assign home_held = home_new_reg & ~rd_home;
    assign home_take = home_ev & ~(home_held & config_reg[`PCU_CFG_HOME_HOLD]);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            home_pos_reg <= '0;
        end else if (home_take) begin
            home_pos_reg <= motor_pos_i;
        end
    end

    // Read clears both flags in its own edge
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            home_new_reg <= 1'b0;
            home_ovr_reg <= 1'b0;
        end else begin
            home_new_reg <= home_ev | home_held;
            home_ovr_reg <= (home_ev & home_held) | (home_ovr_reg & ~rd_home);
        end
    end

    // ----------------------------------------
    // Microsecond time base
    // ----------------------------------------
    // Free running from reset release, wraps after 2^32 microseconds
    localparam int CYC_PER_US = `PCU_CYC_PER_US;
    logic [$clog2(CYC_PER_US)-1:0] us_div_reg;
    pcu_word32_t us_count_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            us_div_reg <= '0;
            us_count_reg <= '0;
        end else if (us_div_reg == ($clog2(CYC_PER_US))'(CYC_PER_US - 1)) begin
            us_div_reg <= '0;
            us_count_reg <= us_count_reg + 32'sh1;
        end else begin
            us_div_reg <= us_div_reg + 1'b1;
        end
    end

    // ----------------------------------------
    // High-speed capture and flags
    // ----------------------------------------
    logic signed [POS_W-1:0] fast_motor_reg;
    logic signed [POS_W-1:0] fast_load_reg;
    pcu_word32_t fast_ts_reg;
    logic fast_new_reg;
    logic fast_ovr_reg;
    logic fast_held;
    logic fast_take;

    assign fast_held = fast_new_reg & ~rd_fast;
    assign fast_take = fast_ev & ~(fast_held & config_reg[`PCU_CFG_FAST_HOLD]);

    // Motor, load and stamp are taken in one edge and stay together
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fast_motor_reg <= '0;
            fast_load_reg <= '0;
        end else if (fast_take) begin
            fast_motor_reg <= motor_pos_i;
            fast_load_reg <= load_pos_i;
        end
    end

    // Capture stamp wins over a software write in the same cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fast_ts_reg <= '0;
        end else if (fast_take) begin
            fast_ts_reg <= us_count_reg;
        end else if (wr_stamp) begin
            fast_ts_reg <= wdata_i;
        end
    end

    // Overrun only while an unread capture waits
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fast_new_reg <= 1'b0;
            fast_ovr_reg <= 1'b0;
        end else begin
            fast_new_reg <= fast_ev | fast_held;
            fast_ovr_reg <= (fast_ev & fast_held) | (fast_ovr_reg & ~rd_fast);
        end
    end

    // ----------------------------------------
    // Actual position clear on index
    // ----------------------------------------
    // Any index rise clears, whatever bits 0 and 1 select
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pos_clear_o <= 1'b0;
        end else begin
            pos_clear_o <= rise[PCU_CH_INDEX] & config_reg[`PCU_CFG_IDX_ZERO];
        end
    end

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    pcu_word16_t flags;

    // Reserved status bits read as zero
    always_comb begin
        flags = '0;
        flags[`PCU_ST_IDX_NEW] = idx_new_reg;
        flags[`PCU_ST_IDX_OVR] = idx_ovr_reg;
        flags[`PCU_ST_HOME_NEW] = home_new_reg;
        flags[`PCU_ST_HOME_OVR] = home_ovr_reg;
        flags[`PCU_ST_FAST_NEW] = fast_new_reg;
        flags[`PCU_ST_FAST_OVR] = fast_ovr_reg;
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        unique case (addr_i)
            `PCU_ADDR_CONFIG: rd_mux = {16'h0000, config_reg};
            `PCU_ADDR_FLAGS: rd_mux = {16'h0000, flags};
            `PCU_ADDR_INDEX_POS: rd_mux = 32'(index_pos_reg);
            `PCU_ADDR_HOME_POS: rd_mux = 32'(home_pos_reg);
            `PCU_ADDR_FAST_TS: rd_mux = fast_ts_reg;
            `PCU_ADDR_FAST_MOTOR: rd_mux = 32'(fast_motor_reg);
            `PCU_ADDR_FAST_LOAD: rd_mux = 32'(fast_load_reg);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= 32'h0000_0000;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_i;
            if (rd_i) begin
                rdata_o <= rd_mux;
            end
        end
    end

endmodule : pcu_top

// *** sim/pcu_top_chk.sv ***
`timescale 1ns/100ps
module pcu_top_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [15:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic index_i,
    input wire logic pos_clear_o
);
    // ----
    // Shadow of the control word
    // ----
    logic [15:0] cfg_reg;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_reg <= 16'h0000;
        end else if (wr_i && addr_i == 16'h2400) begin
            cfg_reg <= wdata_i[15:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    rd_answer_a: assert property (rd_i |=> rvalid_o)
        else $error("read got no answer");
    answer_cause_a: assert property (rvalid_o |-> $past(rd_i))
        else $error("answer without read");
    rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");
    unmapped_zero_a: assert property (rd_i && (addr_i < 16'h2400 || addr_i > 16'h2406) |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property (rd_i && addr_i == 16'h2401 |=> (rdata_o & 32'hffff_0466) == 32'h0)
        else $error("reserved flag set");
    cfg_readback_a: assert property (rd_i && !wr_i && addr_i == 16'h2400 |=> rdata_o == {16'h0000, cfg_reg})
        else $error("control word readback wrong");
    index_clear_a: assert property ($rose(index_i) && cfg_reg[12] |-> ##[3:5] pos_clear_o)
        else $error("index gave no position clear");
    clear_cause_a: assert property (pos_clear_o |-> cfg_reg[12] && !$past(pos_clear_o))
        else $error("position clear unexpected");
endmodule : pcu_top_chk
bind pcu_top pcu_top_chk i_pcu_top_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .rd_i(rd_i),
    .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .index_i(index_i),
    .pos_clear_o(pos_clear_o));

// *** sim/pcu_enc_model.sv ***
`timescale 1ns/100ps
module pcu_enc_model
    import pcu_pkg::*;
(
    input wire logic clk_i,
    input wire logic ld_i,
    input wire pcu_word32_t val_i,
    input wire logic clr_i,
    output pcu_word32_t motor_o,
    output pcu_word32_t load_o
);
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            motor_o <= 32'sh0;
        end else if (ld_i) begin
            motor_o <= val_i;
        end
    end
    // Load side differs from motor side
    assign load_o = ~motor_o;
endmodule : pcu_enc_model

// *** sim/test_position_capture_unit.sv ***
`timescale 1ns/100ps
module test_position_capture_unit;
    import pcu_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic rd_i = 1'b0;
    logic wr_i = 1'b0;
    logic [31:0] wdata_i = 32'h0;
    logic index_i = 1'b0;
    logic home_i = 1'b0;
    logic fast_i = 1'b0;
    logic ld = 1'b0;
    logic h;
    logic [31:0] d;
    logic [15:0] lfsr = 16'hd519;
    pcu_word32_t val = 32'sh0;
    pcu_word32_t p1, p2;
    pcu_word32_t motor, load;
    logic [31:0] rdata_o;
    logic rvalid_o, pos_clear_o;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0 = 0;
    pcu_top #(.POS_W(32), .SYNC_STAGES(2)) i_pcu_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .index_i(index_i), .home_i(home_i), .fast_i(fast_i), .motor_pos_i(motor), .load_pos_i(load),
        .pos_clear_o(pos_clear_o));
    pcu_enc_model i_pcu_enc_model (.clk_i(clk_i), .ld_i(ld), .val_i(val), .clr_i(pos_clear_o),
        .motor_o(motor), .load_o(load));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----
    // Helpers
    // ----
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    function automatic logic [31:0] stw(input logic [5:0] f);
        return {20'h0, f[5], 2'h0, f[4], f[3], 2'h0, f[2], f[1], 2'h0, f[0]};
    endfunction : stw
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge clk_i);
        #1 addr_i = a;
        rd_i = 1'b1;
        @(posedge clk_i);
        #1 rd_i = 1'b0;
        v = rdata_o;
    endtask : rd
    task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask : rc
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk_i);
        #1 addr_i = a;
        wdata_i = v;
        wr_i = 1'b1;
        @(posedge clk_i);
        #1 wr_i = 1'b0;
    endtask : wr
    task automatic pin(input pcu_chan_t ch, input logic lv, output pcu_word32_t p);
        lfsr = nxt(lfsr);
        p[15:0] = lfsr;
        lfsr = nxt(lfsr);
        p[31:16] = lfsr;
        @(posedge clk_i);
        #1 val = p;
        ld = 1'b1;
        @(posedge clk_i);
        #1 ld = 1'b0;
        if (ch == PCU_CH_INDEX) begin
            index_i = lv;
        end else if (ch == PCU_CH_HOME) begin
            home_i = lv;
        end else begin
            fast_i = lv;
        end
        repeat (6) @(posedge clk_i);
    endtask : pin
    task automatic finish_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (10) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        t0 = cyc;
        repeat (3) @(posedge clk_i);
        rc("config reset", 16'h2400, 32'h0);
        rc("status reset", 16'h2401, stw(6'h00));
        rc("unmapped", 16'h2407, 32'h0);
        wr(16'h2400, 32'h0000_0001);
        pin(PCU_CH_INDEX, 1'b1, p1);
        rc("index new", 16'h2401, stw(6'h01));
        wr(16'h2402, 32'h0);
        rc("index pos", 16'h2402, p1);
        rc("index cleared", 16'h2401, stw(6'h00));
        pin(PCU_CH_INDEX, 1'b0, p2);
        rc("index fall off", 16'h2401, stw(6'h00));
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            h = lfsr[0];
            wr(16'h2400, {29'h0, h, 2'h3});
            pin(PCU_CH_INDEX, 1'b1, p1);
            pin(PCU_CH_INDEX, 1'b0, p2);
            rc("index overrun", 16'h2401, stw(6'h03));
            rc("index keep", 16'h2402, h ? p1 : p2);
            rc("index clear", 16'h2401, stw(6'h00));
        end
        wr(16'h2400, 32'h0000_001a);
        rc("config", 16'h2400, 32'h0000_001a);
        pin(PCU_CH_INDEX, 1'b1, p1);
        pin(PCU_CH_INDEX, 1'b0, p2);
        rc("index fall", 16'h2402, p2);
        wr(16'h2400, 32'h0);
        pin(PCU_CH_HOME, 1'b1, p1);
        pin(PCU_CH_HOME, 1'b0, p2);
        pin(PCU_CH_HOME, 1'b1, p2);
        rc("home overrun", 16'h2401, stw(6'h0c));
        rc("home replace", 16'h2403, p2);
        rc("home clear", 16'h2401, stw(6'h00));
        wr(16'h2400, 32'h0000_0060);
        pin(PCU_CH_HOME, 1'b0, p1);
        pin(PCU_CH_HOME, 1'b1, p2);
        rc("home inactive", 16'h2401, stw(6'h04));
        pin(PCU_CH_HOME, 1'b0, p2);
        rc("home keep", 16'h2403, p1);
        rc("home cleared", 16'h2401, stw(6'h00));
        pin(PCU_CH_FAST, 1'b1, p1);
        pin(PCU_CH_FAST, 1'b0, p1);
        rc("fast disabled", 16'h2401, stw(6'h00));
        wr(16'h2400, 32'h0000_0500);
        wr(16'h2404, 32'h0000_1234);
        rc("stamp write", 16'h2404, 32'h0000_1234);
        while ((cyc - t0) % 100 != 40) @(posedge clk_i);
        pin(PCU_CH_FAST, 1'b1, p1);
        rc("stamp", 16'h2404, 32'((cyc - t0) / 100));
        rc("load pos", 16'h2406, ~p1);
        pin(PCU_CH_FAST, 1'b0, p2);
        pin(PCU_CH_FAST, 1'b1, p2);
        rc("fast overrun", 16'h2401, stw(6'h30));
        rc("fast keep", 16'h2405, p1);
        rc("fast clear", 16'h2401, stw(6'h00));
        wr(16'h2400, 32'h0000_0100);
        pin(PCU_CH_FAST, 1'b0, p1);
        pin(PCU_CH_FAST, 1'b1, p1);
        rc("fast new", 16'h2401, stw(6'h10));
        pin(PCU_CH_FAST, 1'b0, p2);
        pin(PCU_CH_FAST, 1'b1, p2);
        rc("fast replace", 16'h2405, p2);
        wr(16'h2400, 32'h0000_1000);
        pin(PCU_CH_INDEX, 1'b1, p1);
        chk("position zeroed", 32'h0, motor);
        finish_test();
    end
endmodule : test_position_capture_unit
